// [rtl/iokw_top.sv]
// key-wakeup general I/O block with serial and LED brightness pin sharing
module iokw_top
#(
	parameter int DATA_W = 32
)
(
	input  wire logic                SYS_CLK,
	input  wire logic                RST_N,
	input  wire logic [7:0]          ADDR,
	input  wire logic [DATA_W-1:0]   WDATA,
	input  wire logic                WR,
	input  wire logic                RD,
	output logic      [DATA_W-1:0]   RDATA,
	input  wire logic [7:0]          PORT_A_PINS_I,
	output logic      [7:0]          PORT_A_PINS_O,
	output logic      [7:0]          PORT_A_PINS_OE,
	input  wire logic [7:0]          PORT_B_PINS_I,
	output logic      [7:0]          PORT_B_PINS_O,
	output logic      [7:0]          PORT_B_PINS_OE,
	input  wire logic [3:0]          PORT_D_PINS_I,
	output logic      [3:0]          PORT_D_PINS_O,
	output logic      [3:0]          PORT_D_PINS_OE,
	input  wire logic                SERIAL_CHIP_SELECT_N,
	input  wire logic                SERIAL_SHIFT_CLOCK,
	input  wire logic                SERIAL_TRANSMIT_DATA,
	output logic                     SERIAL_RECEIVE_DATA,
	output logic                     WAKE_REQ,
	output logic                     IRQ
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DATA_W < 32)
	begin : g_bad_width
		$error("iokw_top: DATA_W must be at least 32");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	iokw_pkg::iokw_port_t                      port_q [iokw_pkg::PORT_CNT];
	iokw_pkg::iokw_port_t                      port_d [iokw_pkg::PORT_CNT];
	iokw_pkg::iokw_ctrl_t                      ctrl_q;
	iokw_pkg::iokw_ctrl_t                      ctrl_d;
	logic [31:0]                               duty_q;
	logic [31:0]                               duty_d;
	logic [iokw_pkg::INT_W-1:0]                stat_q;
	logic [iokw_pkg::INT_W-1:0]                stat_d;
	logic [iokw_pkg::INT_W-1:0]                mask_q;
	logic [iokw_pkg::INT_W-1:0]                mask_d;
	logic [DATA_W-1:0]                         rdata_q;
	logic [DATA_W-1:0]                         rdata_d;
	logic                                      irq_q;
	logic                                      irq_d;
	logic [iokw_pkg::PIN_CNT-1:0]              sync1_q;
	logic [iokw_pkg::PIN_CNT-1:0]              sync2_q;
	logic [iokw_pkg::PIN_CNT-1:0]              sync3_q;
	logic [iokw_pkg::PIN_CNT-1:0]              pin_flt_q;
	logic [iokw_pkg::PIN_CNT-1:0]              pin_flt_d;
	logic [iokw_pkg::INT_W-1:0]                miss_prev_q;
	logic [iokw_pkg::INT_W-1:0]                miss_now;
	logic [iokw_pkg::PWM_W-1:0]                pwm_cnt_q;
	logic [iokw_pkg::PWM_W-1:0]                pwm_cnt_d;
	logic [iokw_pkg::PWM_CH-1:0]               pwm_bit;
	logic [7:0]                                out_q [iokw_pkg::PORT_CNT];
	logic [7:0]                                out_d [iokw_pkg::PORT_CNT];
	logic [7:0]                                oe_q  [iokw_pkg::PORT_CNT];
	logic [7:0]                                oe_d  [iokw_pkg::PORT_CNT];
	logic                                      rx_q;
	logic                                      rx_d;
	logic [iokw_pkg::PIN_CNT-1:0]              raw_pins;
	logic [iokw_pkg::PIN_CNT-1:0]              flat_latch;
	logic [iokw_pkg::PIN_CNT-1:0]              flat_wake;
	logic [iokw_pkg::PIN_CNT-1:0]              raw_miss;
	logic [7:0]                                pin_flt [iokw_pkg::PORT_CNT];

	// ----------------------------------------------------------------
	// pin input filtering
	// ----------------------------------------------------------------
	assign raw_pins = {PORT_D_PINS_I, PORT_B_PINS_I, PORT_A_PINS_I};
	assign pin_flt[iokw_pkg::PORT_A] = pin_flt_q[7:0];
	assign pin_flt[iokw_pkg::PORT_B] = pin_flt_q[15:8];
	assign pin_flt[iokw_pkg::PORT_D] = {4'h0, pin_flt_q[19:16]};

	// a level counts only once stages two and three agree
	always_comb
	begin
		pin_flt_d = ((sync2_q ~^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & pin_flt_q);
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			sync3_q   <= '0;
			pin_flt_q <= '0;
		end
		else
		begin
			sync1_q   <= raw_pins;
			sync2_q   <= sync1_q;
			sync3_q   <= sync2_q;
			pin_flt_q <= pin_flt_d;
		end
	end

	// ----------------------------------------------------------------
	// wakeup compare
	// ----------------------------------------------------------------
	// flattened latch and enable; port D is kept out while the serial interface owns it
	assign flat_latch = {port_q[iokw_pkg::PORT_D].latch[3:0], port_q[iokw_pkg::PORT_B].latch,
	                     port_q[iokw_pkg::PORT_A].latch};
	assign flat_wake  = {port_q[iokw_pkg::PORT_D].wake[3:0] & {4{~ctrl_q.spi_en}},
	                     port_q[iokw_pkg::PORT_B].wake, port_q[iokw_pkg::PORT_A].wake};

	// pure gates on the pins: still valid with the system clock stopped
	assign raw_miss = (raw_pins ^ flat_latch) & flat_wake & {iokw_pkg::PIN_CNT{ctrl_q.wake_on}};
	assign WAKE_REQ = |raw_miss;

	// filtered per-port mismatch feeds the interrupt status
	always_comb
	begin
		for (int p = 0; p < iokw_pkg::PORT_CNT; p++)
		begin
			miss_now[p] = ctrl_q.wake_on & (|((pin_flt[p] ^ port_q[p].latch) & port_q[p].wake));
		end
		miss_now[iokw_pkg::PORT_D] = miss_now[iokw_pkg::PORT_D] & ~ctrl_q.spi_en;
	end

	// ----------------------------------------------------------------
	// led brightness generator
	// ----------------------------------------------------------------
	// duty 0 is dark, 255 is on for 255 of 256 counts
	always_comb
	begin
		pwm_cnt_d = pwm_cnt_q + 8'h01;
		for (int c = 0; c < iokw_pkg::PWM_CH; c++)
		begin
			pwm_bit[c] = pwm_cnt_q < duty_q[c*iokw_pkg::PWM_W +: iokw_pkg::PWM_W];
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [7:0] base;
		logic       lock;
		base   = '0;
		lock   = 1'b0;
		ctrl_d = ctrl_q;
		duty_d = duty_q;
		mask_d = mask_q;
		for (int p = 0; p < iokw_pkg::PORT_CNT; p++)
		begin
			port_d[p] = port_q[p];
			base      = 8'(p) * iokw_pkg::PORT_STRIDE;
			// port D settings are frozen while the serial interface owns the pins
			lock      = (p == iokw_pkg::PORT_D) && ctrl_q.spi_en;
			if (WR && !lock)
			begin
				if (ADDR == base + iokw_pkg::OFS_DATA)
				begin
					port_d[p].latch = WDATA[7:0];
				end
				if (ADDR == base + iokw_pkg::OFS_DIR)
				begin
					port_d[p].dir = WDATA[7:0];
				end
				if (ADDR == base + iokw_pkg::OFS_WAKE)
				begin
					port_d[p].wake = WDATA[7:0];
				end
			end
			if (p == iokw_pkg::PORT_D)
			begin
				port_d[p].latch[7:4] = 4'h0;
				port_d[p].dir[7:4]   = 4'h0;
				port_d[p].wake[7:4]  = 4'h0;
			end
		end
		if (WR && ADDR == iokw_pkg::ADR_CTRL)
		begin
			ctrl_d = iokw_pkg::iokw_ctrl_t'(WDATA[3:0]);
		end
		if (WR && ADDR == iokw_pkg::ADR_DUTY)
		begin
			duty_d = WDATA[31:0];
		end
		if (WR && ADDR == iokw_pkg::ADR_MASK)
		begin
			mask_d = WDATA[iokw_pkg::INT_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// read data and sticky status
	// ----------------------------------------------------------------
	// new mismatch edge wins over a clearing read in the same cycle
	always_comb
	begin
		logic [7:0] base;
		base    = '0;
		rdata_d = '0;
		for (int p = 0; p < iokw_pkg::PORT_CNT; p++)
		begin
			base = 8'(p) * iokw_pkg::PORT_STRIDE;
			if (ADDR == base + iokw_pkg::OFS_DATA)
			begin
				rdata_d[7:0] = pin_flt[p];
			end
			if (ADDR == base + iokw_pkg::OFS_BUF)
			begin
				rdata_d[7:0] = port_q[p].latch;
			end
			if (ADDR == base + iokw_pkg::OFS_DIR)
			begin
				rdata_d[7:0] = port_q[p].dir;
			end
			if (ADDR == base + iokw_pkg::OFS_WAKE)
			begin
				rdata_d[7:0] = port_q[p].wake;
			end
		end
		case (ADDR)
			iokw_pkg::ADR_CTRL: rdata_d[3:0]  = ctrl_q;
			iokw_pkg::ADR_DUTY: rdata_d[31:0] = duty_q;
			iokw_pkg::ADR_STAT: rdata_d[2:0]  = stat_q;
			iokw_pkg::ADR_MASK: rdata_d[2:0]  = mask_q;
			default:            rdata_d       = rdata_d;
		endcase
		if (!RD)
		begin
			rdata_d = '0;
		end
		stat_d = stat_q;
		if (RD && ADDR == iokw_pkg::ADR_STAT)
		begin
			stat_d = '0;
		end
		stat_d = stat_d | (miss_now & ~miss_prev_q);
		irq_d  = |(stat_d & mask_d);
	end

	// ----------------------------------------------------------------
	// pin drive with alternate functions
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int p = 0; p < iokw_pkg::PORT_CNT; p++)
		begin
			out_d[p] = port_q[p].latch;
			oe_d[p]  = port_q[p].dir;
		end
		rx_d = ctrl_q.spi_en & pin_flt[iokw_pkg::PORT_D][iokw_pkg::SPI_RX_BIT];
		if (ctrl_q.pwm_en)
		begin
			if (ctrl_q.pwm_route)
			begin
				out_d[iokw_pkg::PORT_A][3:0] = pwm_bit;
				oe_d[iokw_pkg::PORT_A][3:0]  = 4'hf;
			end
			else
			begin
				out_d[iokw_pkg::PORT_B][3:0] = pwm_bit;
				oe_d[iokw_pkg::PORT_B][3:0]  = 4'hf;
			end
		end
		if (ctrl_q.spi_en)
		begin
			out_d[iokw_pkg::PORT_D][iokw_pkg::SPI_CS_BIT]  = SERIAL_CHIP_SELECT_N;
			out_d[iokw_pkg::PORT_D][iokw_pkg::SPI_SCK_BIT] = SERIAL_SHIFT_CLOCK;
			out_d[iokw_pkg::PORT_D][iokw_pkg::SPI_TX_BIT]  = SERIAL_TRANSMIT_DATA;
			out_d[iokw_pkg::PORT_D][iokw_pkg::SPI_RX_BIT]  = 1'b0;
			oe_d[iokw_pkg::PORT_D][3:0]                    = 4'h7;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int p = 0; p < iokw_pkg::PORT_CNT; p++)
			begin
				port_q[p] <= '{latch: iokw_pkg::RST_PORT, dir: iokw_pkg::RST_PORT, wake: iokw_pkg::RST_PORT};
				out_q[p]  <= iokw_pkg::RST_PORT;
				oe_q[p]   <= iokw_pkg::RST_PORT;
			end
			ctrl_q      <= iokw_pkg::RST_CTRL;
			duty_q      <= iokw_pkg::RST_DUTY;
			stat_q      <= iokw_pkg::RST_INT;
			mask_q      <= iokw_pkg::RST_INT;
			miss_prev_q <= iokw_pkg::RST_INT;
			rdata_q     <= '0;
			irq_q       <= 1'b0;
			rx_q        <= 1'b0;
			pwm_cnt_q   <= '0;
		end
		else
		begin
			for (int p = 0; p < iokw_pkg::PORT_CNT; p++)
			begin
				port_q[p] <= port_d[p];
				out_q[p]  <= out_d[p];
				oe_q[p]   <= oe_d[p];
			end
			ctrl_q      <= ctrl_d;
			duty_q      <= duty_d;
			stat_q      <= stat_d;
			mask_q      <= mask_d;
			miss_prev_q <= miss_now;
			rdata_q     <= rdata_d;
			irq_q       <= irq_d;
			rx_q        <= rx_d;
			pwm_cnt_q   <= pwm_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign RDATA               = rdata_q;
	assign IRQ                 = irq_q;
	assign SERIAL_RECEIVE_DATA = rx_q;
	assign PORT_A_PINS_O       = out_q[iokw_pkg::PORT_A];
	assign PORT_A_PINS_OE      = oe_q[iokw_pkg::PORT_A];
	assign PORT_B_PINS_O       = out_q[iokw_pkg::PORT_B];
	assign PORT_B_PINS_OE      = oe_q[iokw_pkg::PORT_B];
	assign PORT_D_PINS_O       = out_q[iokw_pkg::PORT_D][3:0];
	assign PORT_D_PINS_OE      = oe_q[iokw_pkg::PORT_D][3:0];

endmodule // iokw_top

// [rtl/iokw_pkg.sv]
// constants, field layouts and carrier types of the key-wakeup I/O port block
//
// What this block does
// - Twenty programmable pins are provided: port A with eight bits, port B with eight and port D with four.
// - A data write loads the output latch and the buffer latch together; a data read returns the pin, a buffer read the latch.
// - While wakeup is on, any enabled pin whose level differs from its latched value raises a wakeup request, port D pins only while the serial interface is off.
// - Every pin has its own wakeup enable, independent of its direction and data settings.
// - A triggered wakeup pin is a wakeup source that makes the sleep controller restart the clock and resume execution.
// - With the serial interface on, port D bits 0 to 3 carry chip select, shift clock, transmit data and receive data.
// - While the serial interface is on, its four pins are no general I/O and writes to their I/O settings have no effect.
// - Four LED brightness outputs of 256 levels go either to port B bits 0 to 3 or to port A bits 0 to 3.
package iokw_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int PORT_CNT  = 3;
	localparam int PORT_W    = 8;
	localparam int PORT_D_W  = 4;
	localparam int PIN_CNT   = 20;
	localparam int PWM_CH    = 4;
	localparam int PWM_W     = 8;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] PORT_STRIDE = 8'h10;
	localparam logic [7:0] OFS_DATA    = 8'h00;
	localparam logic [7:0] OFS_BUF     = 8'h04;
	localparam logic [7:0] OFS_DIR     = 8'h08;
	localparam logic [7:0] OFS_WAKE    = 8'h0c;
	localparam logic [7:0] ADR_CTRL    = 8'h30;
	localparam logic [7:0] ADR_DUTY    = 8'h34;
	localparam logic [7:0] ADR_STAT    = 8'h38;
	localparam logic [7:0] ADR_MASK    = 8'h3c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SPI_CS_BIT  = 0;
	localparam int SPI_SCK_BIT = 1;
	localparam int SPI_TX_BIT  = 2;
	localparam int SPI_RX_BIT  = 3;
	localparam int INT_W       = 3;
	localparam int PORT_A      = 0;
	localparam int PORT_B      = 1;
	localparam int PORT_D      = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_PORT = 8'h00;
	localparam logic [31:0] RST_DUTY = 32'h0000_0000;
	localparam logic [2:0]  RST_INT  = 3'h0;

	// control word, low four bits of the control register
	typedef struct packed {
		logic wake_on;   // bit 3: global key-change wakeup enable
		logic pwm_route; // bit 2: 0 = port B, 1 = port A
		logic pwm_en;    // bit 1: LED brightness outputs on
		logic spi_en;    // bit 0: serial interface owns port D
	} iokw_ctrl_t;

	localparam iokw_ctrl_t RST_CTRL = '{wake_on: 1'b0, pwm_route: 1'b0, pwm_en: 1'b0, spi_en: 1'b0};

	// per-port settings
	typedef struct packed {
		logic [7:0] latch; // output data latch, also the buffer
		logic [7:0] dir;   // 1 = output
		logic [7:0] wake;  // per-pin wakeup enable
	} iokw_port_t;

endpackage : iokw_pkg

// [test/iokw_chk.sv]
// assertion checker of the key-wakeup I/O block, bound to its top module
module iokw_chk
#(
	parameter int DATA_W = 32
)
(
	input wire logic              SYS_CLK,
	input wire logic              RST_N,
	input wire logic [7:0]        ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic              WR,
	input wire logic              RD,
	input wire logic [DATA_W-1:0] RDATA,
	input wire logic [7:0]        PORT_A_PINS_OE,
	input wire logic [7:0]        PORT_B_PINS_OE,
	input wire logic [3:0]        PORT_D_PINS_O,
	input wire logic [3:0]        PORT_D_PINS_OE,
	input wire logic              SERIAL_CHIP_SELECT_N,
	input wire logic              SERIAL_SHIFT_CLOCK,
	input wire logic              SERIAL_TRANSMIT_DATA,
	input wire logic              SERIAL_RECEIVE_DATA,
	input wire logic              WAKE_REQ,
	input wire logic              IRQ
);
	// ------------
	// control shadow
	// ------------
	logic [3:0] ctrl_q;
	logic [3:0] ctrl_d;
	logic [2:0] ser_now;
	logic       acc;
	// shadow lets pin ownership be predicted from bus traffic alone
	assign ser_now = {SERIAL_TRANSMIT_DATA, SERIAL_SHIFT_CLOCK, SERIAL_CHIP_SELECT_N};
	assign acc     = RD | WR;
	always_comb
		ctrl_d = (WR && ADDR == iokw_pkg::ADR_CTRL) ? WDATA[3:0] : ctrl_q;
	// same reset as the block, so the shadow never runs ahead of it
	always_ff @(posedge SYS_CLK or negedge RST_N)
		if (!RST_N)
			ctrl_q <= 4'h0;
		else
			ctrl_q <= ctrl_d;
	// ------------
	// properties
	// ------------
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// three settled cycles cover the register stage and the output stage
	sequence s_spi_held;
		ctrl_q[0] [*3];
	endsequence
	sequence s_pwm_on(rt);
		(ctrl_q[2:1] == {rt, 1'b1}) [*3];
	endsequence
	a_rdata_idle: assert property (!RD |=> RDATA == '0)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (RD && (ADDR > 8'h3c || ADDR[1:0] != 2'h0) |=> RDATA == '0)
		else $error("unmapped read returned data");
	a_port_width: assert property (RD && ADDR < 8'h30 |=> RDATA[DATA_W-1:8] == '0)
		else $error("port read has bits above the port width");
	a_port_d_width: assert property (RD && ADDR[7:4] == 4'h2 |=> RDATA[7:4] == 4'h0)
		else $error("port d read has bits above bit 3");
	a_spi_pins: assert property (s_spi_held |-> PORT_D_PINS_OE == 4'h7 && PORT_D_PINS_O[2:0] == $past(ser_now))
		else $error("serial engine does not own port d");
	a_rx_quiet: assert property ((!ctrl_q[0]) [*3] |-> !SERIAL_RECEIVE_DATA)
		else $error("receive data active with serial interface off");
	a_pwm_port_a: assert property (s_pwm_on(1'b1) |-> PORT_A_PINS_OE[3:0] == 4'hf)
		else $error("led outputs not on port a");
	a_pwm_port_b: assert property (s_pwm_on(1'b0) |-> PORT_B_PINS_OE[3:0] == 4'hf)
		else $error("led outputs not on port b");
	a_wake_off: assert property ((!ctrl_q[3]) [*2] |-> !WAKE_REQ)
		else $error("wake request with wakeup disabled");
	a_irq_drop: assert property ($fell(IRQ) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
		else $error("interrupt dropped without an access");
endmodule // iokw_chk

bind iokw_top iokw_chk #(.DATA_W(DATA_W)) u_chk (.SYS_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .PORT_A_PINS_OE,
	.PORT_B_PINS_OE, .PORT_D_PINS_O, .PORT_D_PINS_OE, .SERIAL_CHIP_SELECT_N, .SERIAL_SHIFT_CLOCK,
	.SERIAL_TRANSMIT_DATA, .SERIAL_RECEIVE_DATA, .WAKE_REQ, .IRQ);

// [test/iokw_pins.sv]
// pin-side model: keys with pull-low resistors and the peripheral on port d
module iokw_pins
(
	input wire logic [19:0] drv_o,
	input wire logic [19:0] drv_oe,
	input wire logic [19:0] keys,
	output logic     [19:0] level
);
	// a driven pin follows the block, a released one its key; an open key is 0 as the pull-low makes it
	assign level = (drv_oe & drv_o) | (~drv_oe & keys);
endmodule // iokw_pins

// [test/iokw_top_bench.sv]
// self-checking bench of the key-wakeup I/O block with its pin-side model
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module iokw_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        run = 1'b1;
	logic        rst_n = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        cs_n = 1'b1;
	logic        sck = 1'b0;
	logic        tx = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [19:0] keys = 20'h0;
	logic [19:0] lvl;
	logic [19:0] drv;
	logic [19:0] oe;
	logic [31:0] rdata;
	logic        rx;
	logic        wake;
	logic        irq;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          hits;
	int          lows;
	int          exp_hits[4] = '{0, 64, 128, 255};
	iokw_top dut
	(
		.SYS_CLK(sys_clk),
		.RST_N(rst_n),
		.ADDR(addr),
		.WDATA(wdata),
		.WR(wr),
		.RD(rd),
		.RDATA(rdata),
		.PORT_A_PINS_I(lvl[19:12]),
		.PORT_A_PINS_O(drv[19:12]),
		.PORT_A_PINS_OE(oe[19:12]),
		.PORT_B_PINS_I(lvl[11:4]),
		.PORT_B_PINS_O(drv[11:4]),
		.PORT_B_PINS_OE(oe[11:4]),
		.PORT_D_PINS_I(lvl[3:0]),
		.PORT_D_PINS_O(drv[3:0]),
		.PORT_D_PINS_OE(oe[3:0]),
		.SERIAL_CHIP_SELECT_N(cs_n),
		.SERIAL_SHIFT_CLOCK(sck),
		.SERIAL_TRANSMIT_DATA(tx),
		.SERIAL_RECEIVE_DATA(rx),
		.WAKE_REQ(wake),
		.IRQ(irq)
	);
	iokw_pins pins
	(
		.drv_o(drv),
		.drv_oe(oe),
		.keys(keys),
		.level(lvl)
	);
	// clock gate stands in for sleep
	initial
		forever #4 sys_clk = run ? ~sys_clk : sys_clk;
	// ------------
	// bus tasks
	// ------------
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex);
		@(posedge sys_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		`CHK("read data", ex, rdata)
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ------------
	// tests
	// ------------
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		// every place reads zero after reset, the unmapped one at the end too
		for (int r = 0; r <= 64; r += 4)
			rd_reg(8'(r), 32'h0);
		`CHK("outputs after reset", 22'h0, {oe, wake, irq})
		// data write fills latch and buffer; the buffer place ignores writes
		wr_reg(8'h00, 32'hffff_ff5a);
		wr_reg(8'h20, 32'hffff_ffff);
		wr_reg(8'h04, 32'h0000_0011);
		rd_reg(8'h04, 32'h0000_005a);
		rd_reg(8'h24, 32'h0000_000f);
		wr_reg(8'h08, 32'h0000_00ff);
		tick(6);
		`CHK("port a drive", 16'hff5a, {oe[19:12], drv[19:12]})
		rd_reg(8'h00, 32'h0000_005a);
		wr_reg(8'h08, 32'h0000_0000);
		keys[19:12] <= 8'h33;
		rd_reg(8'h00, 32'h0000_005a);
		tick(6);
		rd_reg(8'h00, 32'h0000_0033);
		rd_reg(8'h04, 32'h0000_005a);
		// one enabled pin on port b; the latch is loaded before wakeup is armed
		@(posedge sys_clk);
		keys[11:4] <= 8'h0f;
		wr_reg(8'h10, 32'h0000_000f);
		wr_reg(8'h1c, 32'h0000_0001);
		wr_reg(8'h30, 32'h0000_0008);
		@(posedge sys_clk);
		keys[11:4] <= 8'h8f;
		tick(6);
		`CHK("wake on disabled pin", 1'b0, wake)
		// with the clock standing still the compare must still see the key
		run = 1'b0;
		#20 keys[4] <= 1'b0;
		#20;
		`CHK("wake with clock stopped", 1'b1, wake)
		run = 1'b1;
		tick(8);
		`CHK("masked event", 1'b0, irq)
		wr_reg(8'h3c, 32'h0000_0002);
		tick(3);
		`CHK("unmasked event", 1'b1, irq)
		rd_reg(8'h38, 32'h0000_0002);
		tick(3);
		`CHK("irq after read", 1'b0, irq)
		rd_reg(8'h38, 32'h0000_0000);
		@(posedge sys_clk);
		keys[11:4] <= 8'h0f;
		tick(1);
		`CHK("wake after key back", 1'b0, wake)
		// serial interface owns port d; settings written meanwhile are lost
		@(posedge sys_clk);
		{cs_n, sck, tx} <= 3'b011;
		keys[3:0] <= 4'h8;
		wr_reg(8'h30, 32'h0000_0001);
		wr_reg(8'h28, 32'h0000_000f);
		wr_reg(8'h20, 32'h0000_0000);
		tick(6);
		`CHK("serial pins", 8'h7d, {oe[3:0], drv[2:0], rx})
		rd_reg(8'h24, 32'h0000_000f);
		wr_reg(8'h30, 32'h0000_0000);
		tick(3);
		`CHK("port d released", 5'h00, {oe[3:0], rx})
		// each duty counted over one full 256-step period, on both routes
		wr_reg(8'h34, 32'hff80_4000);
		for (int rt = 0; rt < 2; rt++)
		begin
			wr_reg(8'h30, 32'(2 + 4 * rt));
			tick(3);
			`CHK("pwm pins", 8'hf0, rt ? {oe[15:12], oe[7:4]} : {oe[7:4], oe[15:12]})
			for (int c = 0; c < 4; c++)
			begin
				hits = 0;
				lows = 0;
				// an unknown level counts as neither high nor low
				repeat (256)
				begin
					hits += int'((rt ? drv[12 + c] : drv[4 + c]) === 1'b1);
					lows += int'((rt ? drv[12 + c] : drv[4 + c]) === 1'b0);
					tick(1);
				end
				`CHK("pwm high count", exp_hits[c], hits)
				`CHK("pwm low count", 256 - exp_hits[c], lows)
			end
		end
		wr_reg(8'h40, 32'hffff_ffff);
		rd_reg(8'h31, 32'h0000_0000);
		conclude();
	end
	// hang guard: the sequence needs about a sixth of this span
	initial
	begin
		#100000;
		n_errors++;
		conclude();
	end
endmodule // iokw_top_bench
